// file: verilog/fpuod_pkg.sv
package fpuod_pkg;
    // addressing byte layout
    localparam int MOD_MSB = 7;
    localparam int MOD_LSB = 6;
    localparam int OPX_MSB = 5;
    localparam int OPX_LSB = 3;
    localparam int RM_MSB  = 2;
    localparam int RM_LSB  = 0;

    // mod encodings
    localparam logic [1:0] MOD_NO_DISP  = 2'h0;
    localparam logic [1:0] MOD_DISP8    = 2'h1;
    localparam logic [1:0] MOD_DISP16   = 2'h2;
    localparam logic [1:0] MOD_REGISTER = 2'h3;

    // r/m encodings with a defined address form
    localparam logic [2:0] RM_BASE_SRC = 3'h0;
    localparam logic [2:0] RM_BASE_DST = 3'h1;
    localparam logic [2:0] RM_DIRECT   = 3'h6;

    // reset values
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [2:0]  RESET_IDX  = 3'h0;
    localparam logic [1:0]  RESET_CNT  = 2'h0;
    localparam logic [7:0]  RESET_BYTE = 8'h00;

    // displacement byte counts per addressing form
    localparam logic [1:0] DISP_NONE = 2'h0;
    localparam logic [1:0] DISP_ONE  = 2'h1;
    localparam logic [1:0] DISP_TWO  = 2'h2;

    typedef enum logic [3:0] {
        FPUOD_IDLE    = 4'h1,
        FPUOD_DISP_LO = 4'h2,
        FPUOD_DISP_HI = 4'h4,
        FPUOD_FINISH  = 4'h8
    } fpuod_state_t;
endpackage

// file: verilog/fpuod_addr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fpuod_addr_if;
    logic [1:0]  mode;
    logic [2:0]  rm;
    logic [15:0] disp;
    logic [15:0] base_register;
    logic [15:0] source_index_register;
    logic [15:0] destination_index_register;
    logic [15:0] effective_address;
    logic        register_form;
    logic        form_supported;

    modport calc (
        input  mode,
        input  rm,
        input  disp,
        input  base_register,
        input  source_index_register,
        input  destination_index_register,
        output effective_address,
        output register_form,
        output form_supported
    );
    modport ctrl (
        output mode,
        output rm,
        output disp,
        output base_register,
        output source_index_register,
        output destination_index_register,
        input  effective_address,
        input  register_form,
        input  form_supported
    );
endinterface
`default_nettype wire

// file: verilog/fpuod_ea_calc.sv
`timescale 1ns/10ps
`default_nettype none
module fpuod_ea_calc (
    fpuod_addr_if.calc a
);
    always_comb begin
        a.effective_address = fpuod_pkg::RESET_WORD;
        a.register_form     = 1'b0;
        a.form_supported    = 1'b0;
        if (a.mode == fpuod_pkg::MOD_REGISTER) begin
            a.register_form  = 1'b1;
            a.form_supported = 1'b1;
        end else if (a.mode == fpuod_pkg::MOD_NO_DISP &&
                     a.rm == fpuod_pkg::RM_DIRECT) begin
            a.effective_address = a.disp;
            a.form_supported    = 1'b1;
        end else begin
            case (a.rm)
                fpuod_pkg::RM_BASE_SRC: begin
                    a.effective_address = 16'(a.base_register
                        + a.source_index_register + a.disp);
                    a.form_supported = 1'b1;
                end
                fpuod_pkg::RM_BASE_DST: begin
                    a.effective_address = 16'(a.base_register
                        + a.destination_index_register + a.disp);
                    a.form_supported = 1'b1;
                end
                // other address forms are flagged, not guessed
                default: begin
                    a.effective_address = fpuod_pkg::RESET_WORD;
                    a.form_supported    = 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: verilog/fpuod_top.sv
// What this block does
// - mod 01: low byte only, sign-extended to 16 bits.
// - mod 11: r/m is a stack-relative register index, not memory.
// - r/m 000 memory: base plus source index plus displacement.
// - r/m 001 memory: base plus destination index plus displacement.
// - direct form r/m 110: high byte over low byte, no register.
// - index i selects register i above stack top (modulo eight); zero selects the top.
// - no-displacement mod, except r/m 110: zero displacement, no displacement bytes.
`timescale 1ns/10ps
`default_nettype none
module fpuod_top (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // instruction byte stream
    input  wire logic        byte_valid_in,
    input  wire logic [7:0]  byte_in,
    // host register file and numeric stack pointer
    input  wire logic [15:0] base_register_in,
    input  wire logic [15:0] source_index_register_in,
    input  wire logic [15:0] destination_index_register_in,
    input  wire logic [2:0]  stack_top_in,
    // decode result
    output logic             busy_out,
    output logic             result_valid_out,
    output logic             register_form_out,
    output logic             form_unsupported_out,
    output logic [15:0]      effective_address_out,
    output logic [15:0]      displacement_out,
    output logic [2:0]       stack_index_out,
    output logic [2:0]       stack_relative_register_out,
    output logic [2:0]       opcode_extension_out
);
    fpuod_pkg::fpuod_state_t state;
    fpuod_pkg::fpuod_state_t next_state;
    logic [1:0]  mode;
    logic [2:0]  rm;
    logic [2:0]  opx;
    logic [7:0]  disp_lo;
    logic [7:0]  disp_hi;
    logic [1:0]  disp_count;
    logic [15:0] disp_word;

    fpuod_addr_if addr ();

    // field pickers for the addressing byte
    function automatic logic [1:0] mode_field(input logic [7:0] b);
        mode_field = b[fpuod_pkg::MOD_MSB:fpuod_pkg::MOD_LSB];
    endfunction

    function automatic logic [2:0] rm_field(input logic [7:0] b);
        rm_field = b[fpuod_pkg::RM_MSB:fpuod_pkg::RM_LSB];
    endfunction

    function automatic logic [2:0] opx_field(input logic [7:0] b);
        opx_field = b[fpuod_pkg::OPX_MSB:fpuod_pkg::OPX_LSB];
    endfunction

    // number of displacement bytes following the addressing byte
    function automatic logic [1:0] disp_bytes(input logic [1:0] m,
                                              input logic [2:0] r);
        case (m)
            fpuod_pkg::MOD_NO_DISP: begin
                if (r == fpuod_pkg::RM_DIRECT) begin
                    disp_bytes = fpuod_pkg::DISP_TWO;
                end else begin
                    disp_bytes = fpuod_pkg::DISP_NONE;
                end
            end
            fpuod_pkg::MOD_DISP8:  disp_bytes = fpuod_pkg::DISP_ONE;
            fpuod_pkg::MOD_DISP16: disp_bytes = fpuod_pkg::DISP_TWO;
            default:               disp_bytes = fpuod_pkg::DISP_NONE;
        endcase
    endfunction

    always_comb begin
        case (disp_count)
            fpuod_pkg::DISP_ONE: disp_word = {{8{disp_lo[7]}}, disp_lo};
            fpuod_pkg::DISP_TWO: disp_word = {disp_hi, disp_lo};
            default:             disp_word = fpuod_pkg::RESET_WORD;
        endcase
    end

    assign addr.mode                       = mode;
    assign addr.rm                         = rm;
    assign addr.disp                       = disp_word;
    assign addr.base_register              = base_register_in;
    assign addr.source_index_register      = source_index_register_in;
    assign addr.destination_index_register = destination_index_register_in;

    fpuod_ea_calc u_calc (
        .a (addr.calc)
    );

    always_comb begin
        next_state = state;
        case (state)
            fpuod_pkg::FPUOD_IDLE: begin
                if (byte_valid_in) begin
                    case (disp_bytes(mode_field(byte_in), rm_field(byte_in)))
                        fpuod_pkg::DISP_NONE: begin
                            next_state = fpuod_pkg::FPUOD_FINISH;
                        end
                        default: begin
                            next_state = fpuod_pkg::FPUOD_DISP_LO;
                        end
                    endcase
                end
            end
            fpuod_pkg::FPUOD_DISP_LO: begin
                if (byte_valid_in) begin
                    next_state = (disp_count == fpuod_pkg::DISP_TWO)
                               ? fpuod_pkg::FPUOD_DISP_HI
                               : fpuod_pkg::FPUOD_FINISH;
                end
            end
            fpuod_pkg::FPUOD_DISP_HI: begin
                if (byte_valid_in) begin
                    next_state = fpuod_pkg::FPUOD_FINISH;
                end
            end
            fpuod_pkg::FPUOD_FINISH: next_state = fpuod_pkg::FPUOD_IDLE;
            default:                 next_state = fpuod_pkg::FPUOD_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= fpuod_pkg::FPUOD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // addressing byte capture
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode <= fpuod_pkg::MOD_NO_DISP;
            rm   <= fpuod_pkg::RESET_IDX;
            opx  <= fpuod_pkg::RESET_IDX;
        end else if (state == fpuod_pkg::FPUOD_IDLE && byte_valid_in) begin
            mode <= mode_field(byte_in);
            rm   <= rm_field(byte_in);
            opx  <= opx_field(byte_in);
        end
    end

    // displacement length, fixed by the addressing byte alone
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            disp_count <= fpuod_pkg::RESET_CNT;
        end else if (state == fpuod_pkg::FPUOD_IDLE && byte_valid_in) begin
            disp_count <= disp_bytes(mode_field(byte_in), rm_field(byte_in));
        end
    end

    // displacement bytes, low first; cleared per instruction so a
    // short form never reuses a stale byte
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            disp_lo <= fpuod_pkg::RESET_BYTE;
            disp_hi <= fpuod_pkg::RESET_BYTE;
        end else if (state == fpuod_pkg::FPUOD_IDLE && byte_valid_in) begin
            disp_lo <= fpuod_pkg::RESET_BYTE;
            disp_hi <= fpuod_pkg::RESET_BYTE;
        end else if (state == fpuod_pkg::FPUOD_DISP_LO && byte_valid_in) begin
            disp_lo <= byte_in;
        end else if (state == fpuod_pkg::FPUOD_DISP_HI && byte_valid_in) begin
            disp_hi <= byte_in;
        end
    end

    // result registers, loaded in the finish cycle; register inputs
    // are sampled then, so the host must hold them until valid
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            register_form_out    <= 1'b0;
            form_unsupported_out <= 1'b0;
            opcode_extension_out <= fpuod_pkg::RESET_IDX;
        end else if (state == fpuod_pkg::FPUOD_FINISH) begin
            register_form_out    <= addr.register_form;
            form_unsupported_out <= !addr.form_supported;
            opcode_extension_out <= opx;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            effective_address_out <= fpuod_pkg::RESET_WORD;
            displacement_out      <= fpuod_pkg::RESET_WORD;
        end else if (state == fpuod_pkg::FPUOD_FINISH) begin
            effective_address_out <= addr.effective_address;
            displacement_out      <= disp_word;
        end
    end

    // stack results stay zero for memory forms so no stale index leaks
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stack_index_out             <= fpuod_pkg::RESET_IDX;
            stack_relative_register_out <= fpuod_pkg::RESET_IDX;
        end else if (state == fpuod_pkg::FPUOD_FINISH) begin
            if (addr.register_form) begin
                stack_index_out <= rm;
                // wraps modulo the eight-entry stack
                stack_relative_register_out <= 3'(stack_top_in + rm);
            end else begin
                stack_index_out             <= fpuod_pkg::RESET_IDX;
                stack_relative_register_out <= fpuod_pkg::RESET_IDX;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= (state == fpuod_pkg::FPUOD_FINISH);
        end
    end

    // busy follows the next state so it drops in the valid cycle
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= (next_state != fpuod_pkg::FPUOD_IDLE);
        end
    end
endmodule
`default_nettype wire

// file: tb/fpuod_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fpuod_checker (
    // clock and reset
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    // byte stream and host state
    input wire logic        byte_valid_in,
    input wire logic [7:0]  byte_in,
    input wire logic [15:0] base_register_in,
    input wire logic [15:0] source_index_register_in,
    input wire logic [15:0] destination_index_register_in,
    input wire logic [2:0]  stack_top_in,
    // decode result
    input wire logic        busy_out,
    input wire logic        result_valid_out,
    input wire logic        register_form_out,
    input wire logic [15:0] effective_address_out,
    input wire logic [15:0] displacement_out,
    input wire logic [2:0]  stack_index_out,
    input wire logic [2:0]  stack_relative_register_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // addressing byte only counts while idle
    wire logic       take = byte_valid_in && !busy_out;
    wire logic [4:0] am   = {byte_in[7:6], byte_in[2:0]};

    AST_DISP8_SEXT: assert property (take && byte_in[7:6] == 2'h1
        ##1 byte_valid_in |-> ##2 result_valid_out
        && displacement_out == 16'($signed($past(byte_in, 2))))
        else $error("short displacement not sign extended");
    AST_REG_INDEX: assert property (take && byte_in[7:6] == 2'h3
        |-> ##2 result_valid_out && register_form_out
        && stack_index_out == $past(byte_in[2:0], 2))
        else $error("register form index wrong");
    AST_BASE_SRC: assert property (take && am == 5'h00 |-> ##2
        effective_address_out == 16'($past(base_register_in)
        + $past(source_index_register_in)))
        else $error("base plus source index wrong");
    AST_BASE_DST: assert property (take && am == 5'h01 |-> ##2
        effective_address_out == 16'($past(base_register_in)
        + $past(destination_index_register_in)))
        else $error("base plus destination index wrong");
    AST_DIRECT: assert property (take && am == 5'h06
        ##1 byte_valid_in [*2] |-> ##2 effective_address_out
        == {$past(byte_in, 2), $past(byte_in, 3)})
        else $error("direct address wrong");
    AST_STACK_REL: assert property (result_valid_out
        && register_form_out |-> stack_relative_register_out
        == 3'($past(stack_top_in) + stack_index_out))
        else $error("stack relative register wrong");
    AST_NO_DISP: assert property (take && byte_in[7:6] == 2'h0
        && byte_in[2:0] != 3'h6 |-> ##2 result_valid_out
        && displacement_out == 16'h0000)
        else $error("no displacement form wrong");
    AST_DISP16: assert property (take && byte_in[7:6] == 2'h2
        ##1 byte_valid_in [*2] |-> ##2 displacement_out
        == {$past(byte_in, 2), $past(byte_in, 3)})
        else $error("long displacement wrong");
    cover property (take && byte_in[7:6] == 2'h3);
    cover property (result_valid_out && !register_form_out);
    cover property (result_valid_out ##2 result_valid_out);
endmodule
bind fpuod_top fpuod_checker u_chk (.clk_in, .rst_n_in, .byte_valid_in,
    .byte_in, .base_register_in, .source_index_register_in,
    .destination_index_register_in, .stack_top_in, .busy_out,
    .result_valid_out, .register_form_out, .effective_address_out,
    .displacement_out, .stack_index_out, .stack_relative_register_out);
`default_nettype wire

// file: tb/fpuod_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module fpuod_host_model (
    // clock
    input wire logic  clk_in,
    // instruction bytes
    output logic      byte_valid_out,
    output logic [7:0] byte_out
);
    initial begin
        byte_valid_out = 1'b0;
        byte_out = 8'h00;
    end
    // addressing byte, then n displacement bytes low first
    task automatic send(input logic [23:0] b, input int n, input bit slow);
        for (int k = 0; k <= n; k++) begin
            if (slow && k > 0) begin
                byte_valid_out = 1'b0;
                byte_out = ~byte_out;
                @(posedge clk_in);
                #2;
            end
            byte_valid_out = 1'b1;
            byte_out = b[8*k+:8];
            @(posedge clk_in);
            #2;
        end
        // idle gap so the next start lands two cycles after the last byte
        byte_valid_out = 1'b0;
        byte_out = ~byte_out;
        @(posedge clk_in);
        #2;
    endtask
endmodule
`default_nettype wire

// file: tb/test_fpuod_top.sv
`timescale 1ns/10ps
`default_nettype none
module test_fpuod_top;
    typedef struct packed {
        logic [15:0] ea, disp;
        logic [2:0]  sidx, srel, ext;
        logic        rf, un;
    } fpuod_exp_t;
    logic clk_in = 1'b0, rst_n_in = 1'b0, byte_valid_in;
    logic busy_out, result_valid_out, register_form_out, form_unsupported_out;
    logic [7:0]  byte_in;
    logic [15:0] base_register_in = 16'h0000;
    logic [15:0] source_index_register_in = 16'h0000;
    logic [15:0] destination_index_register_in = 16'h0000;
    logic [15:0] effective_address_out, displacement_out;
    logic [2:0]  stack_top_in = 3'h0, stack_index_out;
    logic [2:0]  stack_relative_register_out, opcode_extension_out;
    logic [31:0] seed = 32'hF7340E60;
    fpuod_exp_t  q[$];
    int          fail_count = 0, checks = 0;

    always #12.5 clk_in = ~clk_in;
    fpuod_host_model u_host (.clk_in, .byte_valid_out(byte_valid_in),
        .byte_out(byte_in));
    fpuod_top u_dut (.clk_in, .rst_n_in, .byte_valid_in, .byte_in,
        .base_register_in, .source_index_register_in,
        .destination_index_register_in, .stack_top_in, .busy_out,
        .result_valid_out, .register_form_out, .form_unsupported_out,
        .effective_address_out, .displacement_out, .stack_index_out,
        .stack_relative_register_out, .opcode_extension_out);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input logic [15:0] seen, input logic [15:0] exp, string what);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task finish_test;
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin : main
        fpuod_exp_t  e;
        logic [23:0] b;
        logic [1:0]  md;
        logic [2:0]  rm;
        int          n;
        repeat (5) @(posedge clk_in);
        #2 rst_n_in = 1'b1;
        check(16'({busy_out, result_valid_out}), 16'h0000, "reset state");
        // every mod with every r/m, fast then with gaps
        for (int i = 0; i < 64; i++) begin
            seed = lfsr(seed);
            {destination_index_register_in, source_index_register_in} = seed;
            seed = lfsr(seed);
            base_register_in = seed[15:0];
            stack_top_in = seed[18:16];
            seed = lfsr(seed);
            md = 2'(i);
            rm = 3'(i >> 2);
            b = {seed[23:8], md, seed[5:3], rm};
            n = md == 2'h1 ? 1 : (md == 2'h2 || am6(md, rm)) ? 2 : 0;
            e.rf = md == 2'h3;
            e.disp = md == 2'h1 ? 16'($signed(b[15:8])) :
                     n == 2 ? b[23:8] : 16'h0000;
            e.un = !e.rf && !(rm < 3'h2 || am6(md, rm));
            e.ea = (e.un || e.rf) ? 16'h0000 : am6(md, rm) ? e.disp :
                16'(base_register_in + e.disp + (rm == 3'h0 ?
                source_index_register_in : destination_index_register_in));
            e.sidx = e.rf ? rm : 3'h0;
            e.srel = e.rf ? 3'(stack_top_in + rm) : 3'h0;
            e.ext = b[5:3];
            q.push_back(e);
            u_host.send(b, n, i[5]);
        end
        for (int k = 0; k < 8 && q.size() > 0; k++) @(posedge clk_in);
        check(16'(q.size()), 16'h0000, "missing result");
        finish_test();
    end
    function automatic bit am6(logic [1:0] md, logic [2:0] rm);
        return md == 2'h0 && rm == 3'h6;
    endfunction

    always @(posedge clk_in) begin : watch
        fpuod_exp_t e;
        if (result_valid_out === 1'b1) begin
            check(16'(q.size() > 0), 16'h0001, "unexpected result");
            e = q.pop_front();
            check(displacement_out, e.disp, "displacement");
            check(effective_address_out, e.ea, "address");
            check(16'(busy_out), 16'h0000, "busy in valid cycle");
            check(16'({register_form_out, stack_index_out}),
                16'({e.rf, e.sidx}), "register form");
            check(16'(stack_relative_register_out), 16'(e.srel),
                "stack register");
            check(16'({form_unsupported_out, opcode_extension_out}),
                16'({e.un, e.ext}), "form flags");
        end
    end

    initial begin : watchdog
        repeat (20000) @(posedge clk_in);
        fail_count++;
        finish_test();
    end
endmodule
`default_nettype wire
